// file: logic/kmac_pkg.sv
// Shared constants and carrier types for the keypad menu access controller.
// Assumes a single 40 MHz clock domain and no software-visible registers.
package kmac_pkg;

  // ****************************************
  // Menu geometry
  // ****************************************
  localparam int unsigned MENU_COLUMNS       = 11;
  localparam logic [3:0]  MENU_LAST          = 4'hA;
  localparam logic [3:0]  MENU_OPERATOR_INFO = 4'h0;
  localparam logic [3:0]  MENU_COMMANDS      = 4'h1;
  localparam logic [3:0]  SUBMENU_LAST_DFLT  = 4'h7;
  localparam logic [3:0]  SUB_PASSWORD       = 4'h1;
  localparam logic [3:0]  SUB_FEEDER_REF     = 4'h2;

  // ****************************************
  // Characters and password
  // ****************************************
  localparam logic [7:0]  CHAR_A             = 8'h41;
  localparam logic [7:0]  CHAR_Z             = 8'h5A;
  localparam logic [7:0]  CHAR_0             = 8'h30;
  localparam logic [7:0]  CHAR_9             = 8'h39;
  localparam logic [31:0] PASSWORD_RESET     = 32'h41414141;
  localparam logic [31:0] FEEDER_REF_RESET   = 32'h41414141;
  localparam logic [1:0]  LAST_CHAR_IDX      = 2'h3;

  // ****************************************
  // Command orders
  // ****************************************
  localparam int unsigned ORDER_COUNT        = 3;
  localparam logic [1:0]  ORDER_CLEAR_ALL    = 2'h0;
  localparam logic [1:0]  ORDER_START        = 2'h1;
  localparam logic [1:0]  ORDER_STOP         = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam longint unsigned CLK_HZ         = 40000000;
  localparam longint unsigned ACCEPT_MS      = 2000;
  localparam longint unsigned IDLE_S         = 300;
  localparam longint unsigned ACCEPT_CYCLES  = CLK_HZ * ACCEPT_MS / 1000;
  localparam longint unsigned IDLE_CYCLES    = CLK_HZ * IDLE_S;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    SRC_NONE  = 2'h0,
    SRC_KEYS  = 2'h1,
    SRC_FRONT = 2'h3,
    SRC_REAR  = 2'h2
  } kmac_src_t;

  typedef enum logic [3:0] {
    ST_DEFAULT = 4'h0,
    ST_MENU    = 4'h1,
    ST_SUB     = 4'h3,
    ST_PW      = 4'h2,
    ST_PW_OK   = 4'h6,
    ST_EDIT    = 4'h7,
    ST_CONFIRM = 4'h5,
    ST_REF     = 4'h4
  } kmac_state_t;

  typedef struct packed {
    logic up;
    logic down;
    logic left;
    logic right;
    logic enter;
    logic clear;
  } kmac_keys_t;

  typedef struct packed {
    logic        req;
    logic [31:0] value;
  } kmac_wr_t;

  typedef struct packed {
    logic clear_leds;
    logic clear_alarms;
    logic clear_counters;
    logic clear_records;
    logic clear_measures;
    logic release_latches;
    logic start_motor;
    logic stop_motor;
  } kmac_orders_t;

  typedef struct packed {
    logic [31:0] value;
    logic [1:0]  src;
    logic        req;
  } kmac_serial_t;

endpackage

// file: logic/kmac_key_sync.sv
// Two-flop synchroniser and rising-edge pulse for the keypad lines.
// Assumes raw key levels come from pins, asynchronous to clock_i.
`timescale 1ns/1ps
module kmac_key_sync
  import kmac_pkg::*;
#(
  parameter int unsigned WIDTH = 6
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             sys_rst_i,
  // Raw levels and pulses
  input  wire logic [WIDTH-1:0] raw_i,
  output logic      [WIDTH-1:0] press_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] last;
  } kmac_sync_state_t;

  kmac_sync_state_t st_r;
  kmac_sync_state_t st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = raw_i;
    st_nxt.sync = st_r.meta;
    st_nxt.last = st_r.sync;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Only settled copies feed the edge detector
  assign press_o = st_r.sync & ~st_r.last;

endmodule

// file: logic/kmac_top.sv
// Keypad menu navigation, password session and parameter write gate.
// Assumes keypad pins are raw levels; serial requests are clock-synchronous.
//
// How it works
// - Eleven top-level menu columns, some with submenus
// - Down enters menus, left/right step columns
// - Up in a main menu returns default
// - Alarm message overrides default value display
// - Up/down move between submenus within menu
// - Reads free; changes need correct password
// - Four capital letters, factory AAAA, changeable
// - Letter entry: up/down scroll, enter advances
// - Password OK shown, back after two seconds
// - Edit: scroll values, enter next, commit last
// - Five idle minutes end the session
// - Writes only from session-opening interface
// - Keys session blocks both serial ports
// - Clear during edit restores old value
// - Command menu holds exactly three orders
// - Orders act only after confirm_prompt
// - Clear-all clears; latches release without fault
// - Access via keys, front port, rear port
// - Change without session prompts for password
// - Stores four-character feeder reference
`timescale 1ns/1ps
module kmac_top
  import kmac_pkg::*;
#(
  parameter longint unsigned IDLE_LIMIT   = IDLE_CYCLES,
  parameter longint unsigned ACCEPT_LIMIT = ACCEPT_CYCLES,
  parameter logic [3:0]      SUB_LAST     = SUBMENU_LAST_DFLT
) (
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         sys_rst_i,
  // Keypad pins (raw levels)
  input  wire kmac_keys_t   keys_i,
  // Alarm status
  input  wire logic         alarm_i,
  input  wire logic         fault_present_i,
  // Cell value being edited
  input  wire logic [31:0]  cell_value_i,
  // Serial write requests
  input  wire kmac_serial_t serial_i,
  output logic              serial_ack_o,
  output logic              serial_nak_o,
  // Display and menu position
  output logic              show_alarm_o,
  output logic              show_default_o,
  output logic              show_pw_prompt_o,
  output logic              show_pw_ok_o,
  output logic              show_confirm_o,
  output logic              editing_o,
  output logic [3:0]        menu_col_o,
  output logic [3:0]        sub_idx_o,
  output logic [1:0]        char_idx_o,
  output logic [31:0]       edit_value_o,
  // Session
  output logic              unlocked_o,
  output logic [1:0]        session_src_o,
  // Parameter write
  output kmac_wr_t          param_wr_o,
  output logic [31:0]       feeder_ref_o,
  // Orders
  output kmac_orders_t      orders_o
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] char_step(input logic [7:0] c, input logic up, input logic alnum);
    logic [7:0] r;
    r = c;
    if (up) begin
      if (c == CHAR_Z)
        r = alnum ? CHAR_0 : CHAR_A;
      else if (c == CHAR_9)
        r = CHAR_A;
      else
        r = c + 8'h01;
    end else begin
      if (c == CHAR_A)
        r = alnum ? CHAR_9 : CHAR_Z;
      else if (c == CHAR_0)
        r = CHAR_Z;
      else
        r = c - 8'h01;
    end
    return r;
  endfunction

  function automatic logic [31:0] put_char(input logic [31:0] w, input logic [1:0] i,
                                           input logic [7:0] c);
    logic [31:0] r;
    r = w;
    r[8*(3-i) +: 8] = c;
    return r;
  endfunction

  // ****************************************
  // Key synchroniser
  // ****************************************
  logic [5:0] press;
  kmac_keys_t key;

  kmac_key_sync #(
    .WIDTH (6)
  ) u_sync (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .raw_i     (keys_i),
    .press_o   (press)
  );

  assign key = kmac_keys_t'(press);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    kmac_state_t  fsm;
    kmac_state_t  ret;
    logic [3:0]   col;
    logic [3:0]   sub;
    logic [1:0]   cidx;
    logic [31:0]  pw;
    logic [31:0]  pw_try;
    logic [31:0]  edit;
    logic [31:0]  saved;
    logic [31:0]  ref_id;
    logic         pw_change;
    logic [1:0]   order;
    kmac_src_t    src;
    logic [38:0]  idle;
    logic [26:0]  acc;
    kmac_wr_t     wr;
    kmac_orders_t ord;
    logic         s_ack;
    logic         s_nak;
  } kmac_state_vec_t;

  kmac_state_vec_t st_r;
  kmac_state_vec_t st_nxt;

  logic any_key;
  logic unlocked;
  logic in_cmd_menu;

  assign any_key     = |press;
  assign unlocked    = (st_r.src != SRC_NONE);
  assign in_cmd_menu = (st_r.col == MENU_COMMANDS);

  always_comb begin
    st_nxt     = st_r;
    st_nxt.wr  = '0;
    st_nxt.ord = '0;
    st_nxt.s_ack = 1'b0;
    st_nxt.s_nak = 1'b0;

    // ****************************************
    // Session timer
    // ****************************************
    if (unlocked) begin
      if (st_r.src == SRC_KEYS && any_key) begin
        st_nxt.idle = '0;
      end else if (st_r.idle >= 39'(IDLE_LIMIT - 1)) begin
        st_nxt.src  = SRC_NONE;
        st_nxt.idle = '0;
      end else begin
        st_nxt.idle = st_r.idle + 39'h1;
      end
    end

    // ****************************************
    // Serial write gate
    // ****************************************
    if (serial_i.req) begin
      // Serial ports open their own session on request; a keys session locks them out
      if (serial_i.src == SRC_FRONT || serial_i.src == SRC_REAR) begin
        if (st_r.src == kmac_src_t'(serial_i.src)) begin
          st_nxt.wr.req   = 1'b1;
          st_nxt.wr.value = serial_i.value;
          st_nxt.s_ack    = 1'b1;
          st_nxt.idle     = '0;
        end else if (st_r.src == SRC_NONE && serial_i.value == st_r.pw) begin
          st_nxt.src   = kmac_src_t'(serial_i.src);
          st_nxt.idle  = '0;
          st_nxt.s_ack = 1'b1;
        end else begin
          st_nxt.s_nak = 1'b1;
        end
      end else begin
        st_nxt.s_nak = 1'b1;
      end
    end

    // ****************************************
    // Menu and keypad dialogue
    // ****************************************
    unique case (st_r.fsm)
      ST_DEFAULT: begin
        if (key.down) begin
          st_nxt.fsm = ST_MENU;
          st_nxt.col = '0;
        end
      end
      ST_MENU: begin
        if (key.up) begin
          st_nxt.fsm = ST_DEFAULT;
        end else if (key.right) begin
          st_nxt.col = (st_r.col == MENU_LAST) ? 4'h0 : st_r.col + 4'h1;
        end else if (key.left) begin
          st_nxt.col = (st_r.col == 4'h0) ? MENU_LAST : st_r.col - 4'h1;
        end else if (key.down) begin
          st_nxt.fsm = ST_SUB;
          st_nxt.sub = '0;
        end
      end
      ST_SUB: begin
        if (key.up) begin
          if (st_r.sub == 4'h0)
            st_nxt.fsm = ST_MENU;
          else
            st_nxt.sub = st_r.sub - 4'h1;
        end else if (key.down) begin
          if (st_r.sub != SUB_LAST)
            st_nxt.sub = st_r.sub + 4'h1;
        end else if (key.enter) begin
          if (in_cmd_menu && st_r.sub < 4'(ORDER_COUNT)) begin
            st_nxt.order = st_r.sub[1:0];
            st_nxt.fsm   = ST_CONFIRM;
          end else if (st_r.src != SRC_KEYS) begin
            // Reading is free; a change needs the session first
            st_nxt.fsm    = ST_PW;
            st_nxt.ret    = ST_SUB;
            st_nxt.pw_try = {4{CHAR_A}};
            st_nxt.cidx   = '0;
          end else begin
            st_nxt.pw_change = (st_r.col == MENU_OPERATOR_INFO) && (st_r.sub == SUB_PASSWORD);
            st_nxt.cidx  = '0;
            if (st_r.col == MENU_OPERATOR_INFO && st_r.sub == SUB_FEEDER_REF) begin
              st_nxt.fsm   = ST_REF;
              st_nxt.edit  = st_r.ref_id;
              st_nxt.saved = st_r.ref_id;
            end else begin
              st_nxt.fsm   = ST_EDIT;
              st_nxt.edit  = st_nxt.pw_change ? st_r.pw : cell_value_i;
              st_nxt.saved = st_nxt.edit;
            end
          end
        end
      end
      ST_PW: begin
        if (key.up || key.down) begin
          st_nxt.pw_try = put_char(st_r.pw_try, st_r.cidx,
                                   char_step(st_r.pw_try[8*(3-st_r.cidx) +: 8], key.up, 1'b0));
        end else if (key.clear) begin
          st_nxt.fsm = st_r.ret;
        end else if (key.enter) begin
          if (st_r.cidx != LAST_CHAR_IDX) begin
            st_nxt.cidx = st_r.cidx + 2'h1;
          end else if (st_r.pw_try == st_r.pw && st_r.src == SRC_NONE) begin
            st_nxt.src  = SRC_KEYS;
            st_nxt.idle = '0;
            st_nxt.acc  = '0;
            st_nxt.fsm  = ST_PW_OK;
          end else begin
            st_nxt.fsm = st_r.ret;
          end
        end
      end
      ST_PW_OK: begin
        if (st_r.acc >= 27'(ACCEPT_LIMIT - 1))
          st_nxt.fsm = st_r.ret;
        else
          st_nxt.acc = st_r.acc + 27'h1;
      end
      ST_EDIT, ST_REF: begin
        // Session may end on this very edge; leave edit together with it
        if (st_nxt.src != SRC_KEYS) begin
          st_nxt.fsm = ST_SUB;
        end else if (key.clear) begin
          st_nxt.edit = st_r.saved;
          st_nxt.fsm  = ST_SUB;
        end else if (key.up || key.down) begin
          st_nxt.edit = put_char(st_r.edit, st_r.cidx,
                                 char_step(st_r.edit[8*(3-st_r.cidx) +: 8], key.up,
                                           st_r.fsm == ST_REF));
        end else if (key.enter) begin
          if (st_r.cidx != LAST_CHAR_IDX) begin
            st_nxt.cidx = st_r.cidx + 2'h1;
          end else begin
            st_nxt.fsm = ST_SUB;
            if (st_r.fsm == ST_REF)
              st_nxt.ref_id = st_r.edit;
            else if (st_r.pw_change)
              st_nxt.pw = st_r.edit;
            else begin
              st_nxt.wr.req   = 1'b1;
              st_nxt.wr.value = st_r.edit;
            end
          end
        end
      end
      ST_CONFIRM: begin
        if (key.clear || key.up) begin
          st_nxt.fsm = ST_SUB;
        end else if (key.enter) begin
          st_nxt.fsm = ST_SUB;
          unique case (st_r.order)
            ORDER_CLEAR_ALL: begin
              st_nxt.ord.clear_leds      = 1'b1;
              st_nxt.ord.clear_alarms    = 1'b1;
              st_nxt.ord.clear_counters  = 1'b1;
              st_nxt.ord.clear_records   = 1'b1;
              st_nxt.ord.clear_measures  = 1'b1;
              st_nxt.ord.release_latches = ~fault_present_i;
            end
            ORDER_START: st_nxt.ord.start_motor = 1'b1;
            ORDER_STOP:  st_nxt.ord.stop_motor  = 1'b1;
            default: ;
          endcase
        end
      end
      default: st_nxt.fsm = ST_DEFAULT;
    endcase
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r        <= '0;
      st_r.fsm    <= ST_DEFAULT;
      st_r.ret    <= ST_SUB;
      st_r.src    <= SRC_NONE;
      st_r.pw     <= PASSWORD_RESET;
      st_r.pw_try <= PASSWORD_RESET;
      st_r.ref_id <= FEEDER_REF_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Alarm only replaces the default value, not an open menu
  assign show_alarm_o     = (st_r.fsm == ST_DEFAULT) && alarm_i;
  assign show_default_o   = (st_r.fsm == ST_DEFAULT) && !alarm_i;
  assign show_pw_prompt_o = (st_r.fsm == ST_PW);
  assign show_pw_ok_o     = (st_r.fsm == ST_PW_OK);
  assign show_confirm_o   = (st_r.fsm == ST_CONFIRM);
  assign editing_o        = (st_r.fsm == ST_EDIT) || (st_r.fsm == ST_REF);
  assign menu_col_o       = st_r.col;
  assign sub_idx_o        = st_r.sub;
  assign char_idx_o       = st_r.cidx;
  assign edit_value_o     = (st_r.fsm == ST_PW) ? st_r.pw_try : st_r.edit;
  assign unlocked_o       = unlocked;
  assign session_src_o    = st_r.src;
  assign param_wr_o       = st_r.wr;
  assign feeder_ref_o     = st_r.ref_id;
  assign orders_o         = st_r.ord;
  assign serial_ack_o     = st_r.s_ack;
  assign serial_nak_o     = st_r.s_nak;

endmodule

// file: bench/kmac_operator.sv
// Operator model: fingers on the keypad and the two serial hosts.
// Assumes its tasks are called from the bench just after a falling edge.
`timescale 1ns/1ps
module kmac_operator
  import kmac_pkg::*;
(
  // Clock and serial answers
  input  wire logic    clock_i,
  input  wire logic    ack_i,
  input  wire logic    nak_i,
  // Keypad levels and serial request
  output kmac_keys_t   keys_o,
  output kmac_serial_t serial_o
);
  initial begin
    keys_o   = '0;
    serial_o = '0;
  end

  // ****
  // Keypad
  // ****
  // Held past the sync delay; k: 0 up, 1 down, 2 left, 3 right, 4 enter, 5 clear
  task automatic press(input int k);
    keys_o = kmac_keys_t'(6'h20 >> k);
    repeat (4) @(negedge clock_i);
    keys_o = '0;
    repeat (4) @(negedge clock_i);
  endtask

  // ****
  // Serial hosts
  // ****
  // One-cycle request; released lines are inverted so no stale value reads true
  task automatic send(input logic [31:0] v, input logic [1:0] s, output logic [1:0] res);
    serial_o = '{value: v, src: s, req: 1'b1};
    @(negedge clock_i);
    serial_o = '{value: ~v, src: ~s, req: 1'b0};
    res = 2'h0;
    repeat (2) begin
      res = res | {nak_i, ack_i};
      @(negedge clock_i);
    end
  endtask
endmodule

// file: bench/kmac_monitor.sv
// Port-level assertions for the keypad menu access controller.
// Assumes it is bound into kmac_top with the same ACCEPT_LIMIT.
`timescale 1ns/1ps
module kmac_monitor
  import kmac_pkg::*;
#(
  parameter longint unsigned ACCEPT_LIMIT = ACCEPT_CYCLES
) (
  // Clock and reset
  input wire logic         clock_i,
  input wire logic         sys_rst_i,
  // Observed ports
  input wire logic         alarm_i,
  input wire logic         fault_present_i,
  input wire kmac_serial_t serial_i,
  input wire logic         serial_ack_o,
  input wire logic         serial_nak_o,
  input wire logic         show_alarm_o,
  input wire logic         show_default_o,
  input wire logic         show_pw_ok_o,
  input wire logic         show_confirm_o,
  input wire logic         editing_o,
  input wire logic         unlocked_o,
  input wire logic [1:0]   session_src_o,
  input wire kmac_wr_t     param_wr_o,
  input wire kmac_orders_t orders_o
);
  // ****
  // Acceptance message length
  // ****
  longint unsigned pw_cnt_r;
  longint unsigned pw_cnt_nxt;
  always_comb pw_cnt_nxt = show_pw_ok_o ? pw_cnt_r + 1 : '0;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) pw_cnt_r <= '0;
    else pw_cnt_r <= pw_cnt_nxt;
  end

  // ****
  // Checks
  // ****
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  alarm_prio_a: assert property (show_alarm_o |-> alarm_i && !show_default_o)
    else $error("alarm view wrong");
  serial_answer_a: assert property (serial_i.req |=> serial_ack_o != serial_nak_o)
    else $error("serial request not answered once");
  port_lock_a: assert property (unlocked_o && serial_i.req && serial_i.src != session_src_o
    |=> serial_nak_o)
    else $error("foreign port not refused");
  serial_write_a: assert property (serial_ack_o && $past(unlocked_o)
    |-> param_wr_o.req && param_wr_o.value == $past(serial_i.value))
    else $error("accepted serial write lost");
  write_gate_a: assert property (param_wr_o.req |-> $past(unlocked_o))
    else $error("write without session");
  order_confirm_a: assert property (orders_o != '0 |-> $past(show_confirm_o))
    else $error("order without confirm_prompt");
  release_gate_a: assert property (orders_o.release_latches
    |-> orders_o.clear_leds && !$past(fault_present_i))
    else $error("latches released wrongly");
  clear_all_a: assert property (orders_o.clear_leds |-> orders_o[7:3] == 5'h1F)
    else $error("clear-all incomplete");
  pw_ok_src_a: assert property (show_pw_ok_o |-> unlocked_o && session_src_o == 2'h1)
    else $error("acceptance without keys session");
  pw_hold_a: assert property ($fell(show_pw_ok_o)
    |-> pw_cnt_r + 2 >= ACCEPT_LIMIT && pw_cnt_r <= ACCEPT_LIMIT + 2)
    else $error("acceptance message length off");
  edit_session_a: assert property (editing_o |-> unlocked_o)
    else $error("editing while locked");

  cover property (orders_o.start_motor);
  cover property (serial_ack_o && param_wr_o.req);
  cover property ($fell(show_pw_ok_o));
endmodule

bind kmac_top kmac_monitor #(.ACCEPT_LIMIT(ACCEPT_LIMIT)) u_mon (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .alarm_i(alarm_i),
  .fault_present_i(fault_present_i), .serial_i(serial_i), .serial_ack_o(serial_ack_o),
  .serial_nak_o(serial_nak_o), .show_alarm_o(show_alarm_o), .show_default_o(show_default_o),
  .show_pw_ok_o(show_pw_ok_o), .show_confirm_o(show_confirm_o), .editing_o(editing_o),
  .unlocked_o(unlocked_o), .session_src_o(session_src_o), .param_wr_o(param_wr_o),
  .orders_o(orders_o)
);

// file: bench/testbench.sv
// Self-checking bench for the keypad menu access controller.
// Assumes short idle and acceptance counts; inputs change on falling edges.
`timescale 1ns/1ps
module testbench
  import kmac_pkg::*;
;
  localparam int CEILING = 20000;
  logic         clock_i = 1'b0;
  logic         sys_rst_i = 1'b1;
  logic         alarm_i;
  logic         fault_present_i;
  logic [31:0]  cell_value_i;
  kmac_keys_t   keys;
  kmac_serial_t serial;
  kmac_wr_t     param_wr;
  kmac_orders_t orders, ord_val;
  logic         ack, nak, s_alarm, s_default, pw_prompt, pw_ok, confirm, editing, unlocked;
  logic [3:0]   menu_col, sub_idx;
  logic [1:0]   char_idx, session_src, res;
  logic [31:0]  edit_value, feeder_ref, wr_val;
  int           fails = 0, checks_done = 0, cycles = 0, wr_cnt = 0;

  always #12.5 clock_i = ~clock_i;

  kmac_top #(.IDLE_LIMIT(200), .ACCEPT_LIMIT(20)) dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .keys_i(keys), .alarm_i(alarm_i),
    .fault_present_i(fault_present_i), .cell_value_i(cell_value_i), .serial_i(serial),
    .serial_ack_o(ack), .serial_nak_o(nak), .show_alarm_o(s_alarm),
    .show_default_o(s_default), .show_pw_prompt_o(pw_prompt), .show_pw_ok_o(pw_ok),
    .show_confirm_o(confirm), .editing_o(editing), .menu_col_o(menu_col),
    .sub_idx_o(sub_idx), .char_idx_o(char_idx), .edit_value_o(edit_value),
    .unlocked_o(unlocked), .session_src_o(session_src), .param_wr_o(param_wr),
    .feeder_ref_o(feeder_ref), .orders_o(orders)
  );

  kmac_operator op (
    .clock_i(clock_i), .ack_i(ack), .nak_i(nak), .keys_o(keys), .serial_o(serial)
  );

  // ****
  // Reporting and capture
  // ****
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == CEILING) begin
      fails++;
      end_of_test();
    end
  end

  // Pulses last one cycle, so they are latched here for the scenarios
  always @(negedge clock_i) begin
    if (param_wr.req === 1'b1) begin
      wr_cnt++;
      wr_val = param_wr.value;
    end
    if (orders !== '0) ord_val = orders;
  end

  task automatic do_reset();
    sys_rst_i = 1'b1;
    alarm_i = 1'b0;
    fault_present_i = 1'b0;
    cell_value_i = 32'h31323334;
    repeat (16) @(negedge clock_i);
    sys_rst_i = 1'b0;
    wr_cnt = 0;
    ord_val = '0;
    @(negedge clock_i);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_nav();
    do_reset();
    check({s_default, feeder_ref}, {1'b1, 32'h41414141});
    alarm_i = 1'b1;
    @(negedge clock_i);
    check({s_alarm, s_default}, 2'h2);
    alarm_i = 1'b0;
    op.press(1);
    check({s_default, menu_col}, 5'h00);
    repeat (10) op.press(3);
    check(menu_col, MENU_LAST);
    op.press(2);
    check(menu_col, 4'h9);
    repeat (2) op.press(3);
    check(menu_col, 4'h0);
    op.press(0);
    check(s_default, 1'b1);
  endtask

  task automatic t_serial();
    do_reset();
    op.send(32'h41414142, 2'h2, res);
    check({res, unlocked}, 3'h4);
    op.send(PASSWORD_RESET, 2'h2, res);
    check({res, unlocked, session_src}, 5'h0E);
    op.send(32'h12345678, 2'h3, res);
    check({res, wr_cnt[3:0]}, 6'h20);
    op.send(32'h12345678, 2'h2, res);
    check({res, wr_cnt[3:0], wr_val}, {2'h1, 4'h1, 32'h12345678});
    repeat (210) @(negedge clock_i);
    check(unlocked, 1'b0);
  endtask

  task automatic t_keys();
    do_reset();
    op.press(1);
    op.press(1);
    op.press(4);
    check({pw_prompt, edit_value}, {1'b1, PASSWORD_RESET});
    op.press(0);
    check(edit_value[31:24], 8'h42);
    op.press(1);
    repeat (4) op.press(4);
    check({pw_ok, unlocked, session_src}, 4'hD);
    repeat (20) @(negedge clock_i);
    check({pw_ok, pw_prompt, menu_col, sub_idx}, 10'h000);
    op.send(PASSWORD_RESET, 2'h3, res);
    check(res, 2'h2);
    op.press(4);
    check({editing, edit_value}, {1'b1, 32'h31323334});
    cell_value_i = 32'h35363738;
    op.press(0);
    check(edit_value, 32'h32323334);
    op.press(5);
    check({editing, wr_cnt[3:0], edit_value}, {5'h00, 32'h31323334});
    op.press(4);
    repeat (4) op.press(4);
    check({wr_cnt[3:0], wr_val}, {4'h1, 32'h35363738});
    op.press(1);
    op.press(4);
    check({editing, edit_value}, {1'b1, PASSWORD_RESET});
    op.press(0);
    repeat (4) op.press(4);
    check({editing, wr_cnt[3:0]}, 5'h01);
    op.press(1);
    op.press(4);
    op.press(4);
    op.press(1);
    check({char_idx, edit_value}, {2'h1, 32'h41394141});
    repeat (3) op.press(4);
    check(feeder_ref, 32'h41394141);
    repeat (150) @(negedge clock_i);
    op.press(0);
    check(sub_idx, 4'h1);
    repeat (150) @(negedge clock_i);
    check(unlocked, 1'b1);
    repeat (60) @(negedge clock_i);
    check(unlocked, 1'b0);
    op.send(PASSWORD_RESET, 2'h2, res);
    check(res, 2'h2);
    op.send(32'h42414141, 2'h2, res);
    check(res, 2'h1);
  endtask

  task automatic t_order(input int n, input logic f, input logic [7:0] exp);
    do_reset();
    fault_present_i = f;
    op.press(1);
    op.press(3);
    repeat (n + 1) op.press(1);
    check(sub_idx, n[3:0]);
    op.press(4);
    check({confirm, ord_val}, {1'b1, 8'h00});
    op.press(4);
    check(ord_val, exp);
  endtask

  initial begin
    t_nav();
    t_serial();
    t_keys();
    t_order(0, 1'b1, 8'hF8);
    t_order(0, 1'b0, 8'hFC);
    t_order(1, 1'b0, 8'h02);
    t_order(2, 1'b0, 8'h01);
    end_of_test();
  end
endmodule
